// file: rtl/mac_cpw_pkg.sv
// Package with register map, field layout, timing constants and state types.
package mac_cpw_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_HARDWARE_CONFIG_REG = 8'h00;
  localparam logic [7:0] OFS_FLOW = 8'h04;
  localparam logic [7:0] OFS_WAKE_A = 8'h08;
  localparam logic [7:0] OFS_WAKE_B = 8'h0C;
  localparam logic [7:0] OFS_PMC = 8'h10;
  localparam logic [7:0] OFS_CAUSE = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  // Field positions.
  localparam int F_FDX = 0;
  localparam int F_SPD = 1;
  localparam int F_BOSEL = 4;
  localparam int F_QUANTA = 0;
  localparam int F_RXHON = 16;
  localparam int F_AUTO = 17;
  localparam int F_PASS = 18;
  localparam int F_FORCE = 19;
  localparam int F_ST = 8;
  localparam int F_MEN = 0;
  localparam int F_WST = 1;
  localparam int F_WEN = 2;
  localparam int F_SLEEP = 4;
  localparam int F_HOLD = 16;
  localparam int F_ATT = 20;
  // Speed codes.
  localparam logic [1:0] SPD_GIG = 2'h2;
  // Reset values.
  localparam logic [15:0] QUANTA_RST = 16'hFFFF;
  localparam logic [1:0] BOSEL_RST = 2'h0;
  // Timing: a slot is 512 bit times, a jam is 32 bit times.
  localparam int SLOT_BITS = 512;
  localparam int JAM_BITS = 32;
  localparam int ATTEMPT_LIMIT = 16;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01,
    TX_JAM = 2'b10,
    TX_BACKOFF = 2'b11
  } tx_e;
  typedef enum logic [1:0] {
    SL_NORMAL = 2'b00,
    SL_ZERO = 2'b01,
    SL_THREE = 2'b11
  } sleep_e;
  typedef struct packed {
    logic [31:0] dat;
    logic ack;
  } wb_rsp_s;
  typedef struct packed {
    logic req;
    logic [15:0] val;
  } pause_tx_s;
endpackage

// file: rtl/sync2.sv
// Two flip-flop synchroniser for inputs from outside the clock domain.
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o <= '0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

// file: rtl/mac_collision_pause_wake_ctrl.sv
// Collision retry, pause flow control and wake-on-LAN control for the MAC.
// Function
// - Collision while sending: stop data, send jam.
// - Retry after truncated exponential back-off in slots.
// - Collision raises replay request to FIFO controller.
// - Frame done request after success or abort.
// - No half duplex collisions at gigabit speed.
// - Pause frame quanta in 512 bit times.
// - Honoured pause holds off data frame transmission.
// - Pause arriving mid-frame starts after that frame.
// - Pass pause frames up only when enabled.
// - Force bit sends one pause with quanta.
// - Auto pause send on FIFO watermark indications.
// - Flow-on sends pause with configured time.
// - Flow-off sends pause with zero time.
// - Hysteresis: on, then off, before another on.
// - Wake only from enabled detectors.
// - Suspended enabled match sets status, cause, wake.
// - Deepest sleep stores the waking frame.
// - Resume may wipe status; cause kept.
// - Resume may wipe all wake enables.
// - Resume returns device to normal state.
// - One packet may set several status bits.
// - Gigabit full duplex; 10/100 either duplex.
`timescale 1ns/1ps
module mac_collision_pause_wake_ctrl
  import mac_cpw_pkg::*;
#(
  parameter int BITS_PER_EDGE = 4,
  parameter int SLOT_EDGES = SLOT_BITS / BITS_PER_EDGE,
  parameter int JAM_EDGES = JAM_BITS / BITS_PER_EDGE
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Pins from the PHY side.
  input wire logic link_clk_i,
  input wire logic col_i,
  // Transmit engine.
  input wire logic tx_start_i,
  input wire logic tx_end_i,
  output logic jam_o,
  output logic tx_hold_o,
  output logic pause_req_o,
  output logic [15:0] pause_val_o,
  input wire logic pause_sent_i,
  // FIFO controller.
  output logic frame_replay_req_o,
  output logic frame_done_req_o,
  input wire logic flow_on_i,
  input wire logic flow_off_i,
  // Receive parser.
  input wire logic rx_pause_det_i,
  input wire logic [15:0] rx_pause_quanta_i,
  output logic rx_pass_ctrl_o,
  input wire logic pkt_end_i,
  input wire logic [5:0] det_hits_i,
  output logic store_wake_frame_o,
  // Host power side.
  input wire logic host_resume_i,
  output logic wake_o
);
  typedef struct packed {
    tx_e txs;
    logic [4:0] attempts;
    logic [15:0] edge_cnt;
    logic late;
    logic [9:0] backoff;
    logic [15:0] slot_div;
    logic [9:0] lfsr;
    logic [15:0] pause_cnt;
    logic [15:0] pause_pend;
    logic pend_v;
    logic fdx;
    logic [1:0] speed;
    logic [1:0] bo_sel;
    logic [15:0] quanta;
    logic rx_honor;
    logic auto_en;
    logic pass_up;
    logic force_pend;
    logic on_sent;
    pause_tx_s ptx;
    logic [3:0] en_a;
    logic [3:0] st_a;
    logic [1:0] en_b;
    logic [1:0] st_b;
    logic [5:0] cause;
    logic men;
    logic wipe_st;
    logic wipe_en;
    sleep_e sleep;
    logic wake;
    logic store;
    logic replay;
    logic done;
    logic lclk_d;
    logic res_d;
    wb_rsp_s wb;
  } state_s;

  localparam logic [15:0] SLOT_LAST = 16'(SLOT_EDGES - 1);
  // A jam shorter than one link edge still lasts one edge, so the jam state always ends.
  localparam logic [15:0] JAM_LAST = 16'((JAM_EDGES > 1) ? JAM_EDGES - 1 : 0);
  localparam logic [4:0] ATT_MAX = 5'(ATTEMPT_LIMIT);

  state_s s_reg;
  state_s s_next;
  logic lclk_s;
  logic col_s;
  logic res_s;

  // Pins are asynchronous to clk_i; the link clock is sampled, not used as a clock.
  sync2 #(.W(3)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({link_clk_i, col_i, host_resume_i}),
    .q_o({lclk_s, col_s, res_s})
  );

  logic link_edge;
  logic slot_tick;
  logic half_dup;
  logic res_edge;
  logic [3:0] bo_k;
  logic [9:0] bo_mask;
  logic [3:0] k_lim;
  logic [5:0] hits;
  logic wb_go;

  always_comb begin
    link_edge = lclk_s && !s_reg.lclk_d;
    slot_tick = link_edge && (s_reg.slot_div == SLOT_LAST);
    half_dup = !s_reg.fdx && (s_reg.speed != SPD_GIG);
    res_edge = res_s && !s_reg.res_d;
    wb_go = cyc_i && stb_i && !s_reg.wb.ack;
    case (s_reg.bo_sel)
      2'h0: k_lim = 4'hA;
      2'h1: k_lim = 4'h8;
      2'h2: k_lim = 4'h4;
      default: k_lim = 4'h1;
    endcase
    // Exponent grows with attempts and is truncated by the selected limit.
    bo_k = (s_reg.attempts >= 5'(k_lim)) ? k_lim : 4'(s_reg.attempts + 5'h01);
    bo_mask = 10'((11'h001 << bo_k) - 11'h001);
    hits = det_hits_i & {s_reg.en_b, s_reg.en_a};
  end

  always_comb begin
    s_next = s_reg;
    s_next.lclk_d = lclk_s;
    s_next.res_d = res_s;
    s_next.replay = 1'b0;
    s_next.done = 1'b0;
    s_next.store = 1'b0;
    s_next.wb.ack = wb_go;
    s_next.lfsr = {s_reg.lfsr[8:0], s_reg.lfsr[9] ^ s_reg.lfsr[6]};
    if (link_edge) begin
      s_next.slot_div = slot_tick ? 16'h0000 : s_reg.slot_div + 16'h0001;
    end
    //////////////////////////////////////////////////////////////////////////
    // Transmit collision state machine.
    case (s_reg.txs)
      TX_IDLE: begin
        if (tx_start_i) begin
          s_next.txs = TX_SEND;
          s_next.edge_cnt = 16'h0000;
          s_next.late = 1'b0;
        end
      end
      TX_SEND: begin
        if (link_edge && s_reg.edge_cnt != 16'(SLOT_EDGES)) begin
          s_next.edge_cnt = s_reg.edge_cnt + 16'h0001;
        end
        if (col_s && half_dup) begin
          s_next.txs = TX_JAM;
          s_next.late = (s_reg.edge_cnt == 16'(SLOT_EDGES));
          s_next.edge_cnt = 16'h0000;
        end else if (tx_end_i) begin
          s_next.txs = TX_IDLE;
          s_next.done = 1'b1;
          s_next.attempts = 5'h00;
        end
      end
      TX_JAM: begin
        if (link_edge) begin
          s_next.edge_cnt = s_reg.edge_cnt + 16'h0001;
          if (s_reg.edge_cnt == JAM_LAST) begin
            if (s_reg.late || s_reg.attempts + 5'h01 >= ATT_MAX) begin
              s_next.txs = TX_IDLE;
              s_next.done = 1'b1;
              s_next.attempts = 5'h00;
            end else begin
              s_next.txs = TX_BACKOFF;
              s_next.replay = 1'b1;
              s_next.attempts = s_reg.attempts + 5'h01;
              s_next.backoff = s_reg.lfsr & bo_mask;
            end
          end
        end
      end
      TX_BACKOFF: begin
        if (s_reg.backoff == 10'h000) begin
          s_next.txs = TX_IDLE;
        end else if (slot_tick) begin
          s_next.backoff = s_reg.backoff - 10'h001;
        end
      end
      default: s_next.txs = TX_IDLE;
    endcase
    //////////////////////////////////////////////////////////////////////////
    // Received pause: a frame in flight defers the reload until it ends.
    if (s_reg.pause_cnt != 16'h0000 && slot_tick && s_reg.txs == TX_IDLE) begin
      s_next.pause_cnt = s_reg.pause_cnt - 16'h0001;
    end
    if (s_reg.pend_v && s_reg.txs == TX_IDLE) begin
      s_next.pause_cnt = s_reg.pause_pend;
      s_next.pend_v = 1'b0;
    end
    if (rx_pause_det_i && s_reg.rx_honor) begin
      if (s_reg.txs == TX_IDLE) begin
        s_next.pause_cnt = rx_pause_quanta_i;
      end else begin
        s_next.pause_pend = rx_pause_quanta_i;
        s_next.pend_v = 1'b1;
      end
    end
    //////////////////////////////////////////////////////////////////////////
    // Pause transmission requests.
    if (pause_sent_i) begin
      s_next.ptx.req = 1'b0;
    end
    if (!s_reg.ptx.req) begin
      if (s_reg.force_pend) begin
        s_next.ptx = '{req: 1'b1, val: s_reg.quanta};
        s_next.force_pend = 1'b0;
      end else if (s_reg.auto_en && flow_on_i && !s_reg.on_sent) begin
        s_next.ptx = '{req: 1'b1, val: s_reg.quanta};
        s_next.on_sent = 1'b1;
      end else if (s_reg.auto_en && flow_off_i && s_reg.on_sent) begin
        s_next.ptx = '{req: 1'b1, val: 16'h0000};
        s_next.on_sent = 1'b0;
      end
    end
    //////////////////////////////////////////////////////////////////////////
    // Wake sequence.
    if (res_edge && s_reg.sleep != SL_NORMAL) begin
      if (s_reg.wipe_st) begin
        s_next.st_a = 4'h0;
        s_next.st_b = 2'h0;
      end
      if (s_reg.wipe_en) begin
        s_next.en_a = 4'h0;
        s_next.en_b = 2'h0;
      end
      s_next.sleep = SL_NORMAL;
      s_next.wake = 1'b0;
    end else if (pkt_end_i && s_reg.sleep != SL_NORMAL && s_reg.men && hits != 6'h00) begin
      s_next.st_a = s_reg.st_a | hits[3:0];
      s_next.st_b = s_reg.st_b | hits[5:4];
      s_next.cause = s_reg.cause | hits;
      s_next.wake = 1'b1;
      s_next.store = (s_reg.sleep == SL_THREE);
    end
    //////////////////////////////////////////////////////////////////////////
    // Register access; hardware sets above win over write-one-to-clear.
    s_next.wb.dat = 32'h0000_0000;
    if (wb_go && we_i && sel_i[0]) begin
      if (adr_i == OFS_HARDWARE_CONFIG_REG) begin
        s_next.fdx = dat_i[F_FDX];
        s_next.speed = dat_i[F_SPD+:2];
        s_next.bo_sel = dat_i[F_BOSEL+:2];
      end else if (adr_i == OFS_FLOW) begin
        s_next.quanta = dat_i[F_QUANTA+:16];
        s_next.rx_honor = dat_i[F_RXHON];
        s_next.auto_en = dat_i[F_AUTO];
        s_next.pass_up = dat_i[F_PASS];
        s_next.force_pend = s_reg.force_pend | dat_i[F_FORCE];
      end else if (adr_i == OFS_WAKE_A) begin
        s_next.en_a = dat_i[3:0];
        s_next.st_a = s_next.st_a & ~(dat_i[F_ST+:4] & ~hits[3:0]);
      end else if (adr_i == OFS_WAKE_B) begin
        s_next.en_b = dat_i[1:0];
        s_next.st_b = s_next.st_b & ~(dat_i[F_ST+:2] & ~hits[5:4]);
      end else if (adr_i == OFS_PMC) begin
        s_next.men = dat_i[F_MEN];
        s_next.wipe_st = dat_i[F_WST];
        s_next.wipe_en = dat_i[F_WEN];
        s_next.sleep = sleep_e'(dat_i[F_SLEEP+:2]);
      end else if (adr_i == OFS_CAUSE) begin
        s_next.cause = s_next.cause & ~(dat_i[5:0] & ~hits);
      end
    end else if (wb_go && !we_i) begin
      if (adr_i == OFS_HARDWARE_CONFIG_REG) begin
        s_next.wb.dat[F_FDX] = s_reg.fdx;
        s_next.wb.dat[F_SPD+:2] = s_reg.speed;
        s_next.wb.dat[F_BOSEL+:2] = s_reg.bo_sel;
      end else if (adr_i == OFS_FLOW) begin
        s_next.wb.dat[F_QUANTA+:16] = s_reg.quanta;
        s_next.wb.dat[F_RXHON] = s_reg.rx_honor;
        s_next.wb.dat[F_AUTO] = s_reg.auto_en;
        s_next.wb.dat[F_PASS] = s_reg.pass_up;
        s_next.wb.dat[F_FORCE] = s_reg.force_pend;
      end else if (adr_i == OFS_WAKE_A) begin
        s_next.wb.dat[3:0] = s_reg.en_a;
        s_next.wb.dat[F_ST+:4] = s_reg.st_a;
      end else if (adr_i == OFS_WAKE_B) begin
        s_next.wb.dat[1:0] = s_reg.en_b;
        s_next.wb.dat[F_ST+:2] = s_reg.st_b;
      end else if (adr_i == OFS_PMC) begin
        s_next.wb.dat[F_MEN] = s_reg.men;
        s_next.wb.dat[F_WST] = s_reg.wipe_st;
        s_next.wb.dat[F_WEN] = s_reg.wipe_en;
        s_next.wb.dat[F_SLEEP+:2] = s_reg.sleep;
      end else if (adr_i == OFS_CAUSE) begin
        s_next.wb.dat[5:0] = s_reg.cause;
      end else if (adr_i == OFS_STAT) begin
        s_next.wb.dat[15:0] = s_reg.pause_cnt;
        s_next.wb.dat[F_HOLD] = tx_hold_o;
        s_next.wb.dat[F_ATT+:5] = s_reg.attempts;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.lfsr <= 10'h3FF;
      s_reg.quanta <= QUANTA_RST;
      s_reg.bo_sel <= BOSEL_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Hold only gates new frame starts, so a frame already on the wire completes.
  assign tx_hold_o = (s_reg.pause_cnt != 16'h0000);
  assign jam_o = (s_reg.txs == TX_JAM);
  assign frame_replay_req_o = s_reg.replay;
  assign frame_done_req_o = s_reg.done;
  assign pause_req_o = s_reg.ptx.req;
  assign pause_val_o = s_reg.ptx.val;
  assign rx_pass_ctrl_o = rx_pause_det_i && s_reg.pass_up;
  assign store_wake_frame_o = s_reg.store;
  assign wake_o = s_reg.wake;
  assign dat_o = s_reg.wb.dat;
  assign ack_o = s_reg.wb.ack;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence col_in_send;
    s_reg.txs == TX_SEND && col_s && half_dup;
  endsequence
  sequence jam_ends_ok;
    s_reg.txs == TX_JAM && link_edge && s_reg.edge_cnt == JAM_LAST && !s_reg.late
      && s_reg.attempts + 5'h01 < ATT_MAX;
  endsequence

  jam_on_col_a: assert property (col_in_send |=> jam_o) else $error("no jam");
  replay_after_jam_a: assert property (jam_ends_ok |=> frame_replay_req_o
    && s_reg.txs == TX_BACKOFF && s_reg.backoff <= bo_mask) else $error("no replay");
  replay_once_a: assert property (frame_replay_req_o |=> !frame_replay_req_o)
    else $error("replay not a pulse");
  done_on_end_a: assert property (s_reg.txs == TX_SEND && tx_end_i && !col_s |=>
    frame_done_req_o) else $error("no done");
  no_gig_jam_a: assert property (s_reg.speed == SPD_GIG && s_reg.txs == TX_SEND |=>
    !jam_o) else $error("jam at gigabit");
  pause_load_a: assert property (rx_pause_det_i && s_reg.rx_honor && s_reg.txs == TX_IDLE
    |=> s_reg.pause_cnt == $past(rx_pause_quanta_i)) else $error("pause not loaded");
  pass_gate_a: assert property (rx_pass_ctrl_o |-> s_reg.pass_up)
    else $error("pause passed up");
  off_zero_a: assert property (!s_reg.ptx.req && !s_reg.force_pend && s_reg.auto_en
    && flow_off_i && s_reg.on_sent |=> pause_req_o && pause_val_o == 16'h0000)
    else $error("bad off pause");
  wake_set_a: assert property (pkt_end_i && s_reg.sleep != SL_NORMAL && s_reg.men
    && hits != 6'h00 && !res_edge |=> wake_o && (s_reg.cause & $past(hits)) == $past(hits))
    else $error("no wake");
  resume_wipe_a: assert property (res_edge && s_reg.sleep != SL_NORMAL && s_reg.wipe_st
    |=> s_reg.st_a == 4'h0 && s_reg.sleep == SL_NORMAL) else $error("status kept");
endmodule

// file: bench/phy_side_model.sv
// Line-side partner model: link clock and collision pin.
`timescale 1ns/1ps
module phy_side_model #(
  parameter real HALF_NS = 32.0
) (
  // Commands from the bench.
  input wire logic col_cmd_i,
  // Line pins.
  output logic link_clk_o,
  output logic col_o
);
  // The line clock runs free so the pause countdown can advance between frames.
  initial begin
    link_clk_o = 1'b0;
    #3;
    forever #(HALF_NS) link_clk_o = ~link_clk_o;
  end
  // Collision is only raised when a scenario asks for one.
  assign col_o = col_cmd_i;
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the collision, pause and wake controller.
`timescale 1ns/1ps
module tb_top;
  import mac_cpw_pkg::*;
  logic clk_i, rst_i, we_i, cyc_i, stb_i, tx_start_i, tx_end_i, pause_sent_i, flow_on_i;
  logic flow_off_i, rx_pause_det_i, pkt_end_i, host_resume_i, col_cmd, link_clk_i, col_i;
  logic ack_o, jam_o, tx_hold_o, pause_req_o, frame_replay_req_o, frame_done_req_o;
  logic rx_pass_ctrl_o, store_wake_frame_o, wake_o, seen_jam, seen_rep, seen_done, seen_store;
  logic [7:0] adr_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [3:0] sel_i;
  logic [15:0] rx_pause_quanta_i, pause_val_o;
  logic [5:0] det_hits_i;
  int num_errors = 0;
  int tests_run = 0;
  localparam logic [4:0] P_START = 5'h10;
  localparam logic [4:0] P_END = 5'h08;
  localparam logic [4:0] P_SENT = 5'h04;
  localparam logic [4:0] P_ON = 5'h02;
  localparam logic [4:0] P_OFF = 5'h01;
  ////////////////////////////////////////////////////////////////////////////////
  // A short slot (8 link edges) keeps back-off and pause waits brief.
  mac_collision_pause_wake_ctrl #(.BITS_PER_EDGE(64)) u_mac_collision_pause_wake_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .link_clk_i(link_clk_i),
    .col_i(col_i), .tx_start_i(tx_start_i), .tx_end_i(tx_end_i), .jam_o(jam_o),
    .tx_hold_o(tx_hold_o), .pause_req_o(pause_req_o), .pause_val_o(pause_val_o),
    .pause_sent_i(pause_sent_i), .frame_replay_req_o(frame_replay_req_o),
    .frame_done_req_o(frame_done_req_o), .flow_on_i(flow_on_i), .flow_off_i(flow_off_i),
    .rx_pause_det_i(rx_pause_det_i), .rx_pause_quanta_i(rx_pause_quanta_i),
    .rx_pass_ctrl_o(rx_pass_ctrl_o), .pkt_end_i(pkt_end_i), .det_hits_i(det_hits_i),
    .store_wake_frame_o(store_wake_frame_o), .host_resume_i(host_resume_i), .wake_o(wake_o));
  phy_side_model u_phy_side_model (.col_cmd_i(col_cmd), .link_clk_o(link_clk_i), .col_o(col_i));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Pulses are latched at the falling edge, where outputs are settled.
  always @(negedge clk_i) begin
    if (jam_o === 1'b1) seen_jam = 1'b1;
    if (frame_replay_req_o === 1'b1) seen_rep = 1'b1;
    if (frame_done_req_o === 1'b1) seen_done = 1'b1;
    if (store_wake_frame_o === 1'b1) seen_store = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic err(input string m);
    num_errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) err($sformatf("pin got %b exp %b", got, exp));
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) err($sformatf("word got %h exp %h", got, exp));
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic clr();
    seen_jam = 1'b0;
    seen_rep = 1'b0;
    seen_done = 1'b0;
    seen_store = 1'b0;
  endtask
  task automatic pulse(input logic [4:0] m);
    {tx_start_i, tx_end_i, pause_sent_i, flow_on_i, flow_off_i} <= m;
    @(posedge clk_i);
    {tx_start_i, tx_end_i, pause_sent_i, flow_on_i, flow_off_i} <= 5'h00;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    @(posedge clk_i);
    // Only the watchdog ends a wait for the answer.
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk_word(rd, exp);
  endtask
  task automatic rx_pause(input logic [15:0] q, input logic pass);
    rx_pause_quanta_i <= q;
    rx_pause_det_i <= 1'b1;
    @(negedge clk_i);
    chk_bit(rx_pass_ctrl_o, pass);
    @(posedge clk_i);
    rx_pause_det_i <= 1'b0;
    tick(2);
  endtask
  task automatic packet(input logic [5:0] h);
    pkt_end_i <= 1'b1;
    det_hits_i <= h;
    @(posedge clk_i);
    pkt_end_i <= 1'b0;
    det_hits_i <= 6'h00;
    tick(2);
  endtask
  task automatic resume();
    host_resume_i <= 1'b1;
    tick(8);
    host_resume_i <= 1'b0;
    tick(2);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd_chk(OFS_FLOW, 32'h0000FFFF);
    rd_chk(OFS_HARDWARE_CONFIG_REG, 32'h00000000);
    wb(1'b1, 8'h1C, 32'hFFFFFFFF);
    rd_chk(8'h1C, 32'h00000000);
  endtask
  task automatic t_collide(input int delay, input logic late);
    clr();
    pulse(P_START);
    tick(delay);
    col_cmd <= 1'b1;
    tick(4);
    col_cmd <= 1'b0;
    tick(60);
    chk_bit(seen_jam, 1'b1);
    chk_bit(seen_rep, !late);
    chk_bit(seen_done, late);
    tick(300);
  endtask
  task automatic t_collision();
    t_collide(4, 1'b0);
    clr();
    pulse(P_START);
    tick(4);
    pulse(P_END);
    tick(3);
    chk_bit(seen_done, 1'b1);
    t_collide(120, 1'b1);
    wb(1'b1, OFS_HARDWARE_CONFIG_REG, 32'h00000005);
    clr();
    pulse(P_START);
    tick(4);
    col_cmd <= 1'b1;
    tick(4);
    col_cmd <= 1'b0;
    tick(40);
    chk_bit(seen_jam, 1'b0);
    pulse(P_END);
    tick(3);
    chk_bit(seen_done, 1'b1);
    wb(1'b1, OFS_HARDWARE_CONFIG_REG, 32'h00000000);
  endtask
  task automatic t_pause_send();
    wb(1'b1, OFS_FLOW, 32'h00081234);
    tick(2);
    chk_bit(pause_req_o, 1'b1);
    chk_word({16'h0000, pause_val_o}, 32'h00001234);
    pulse(P_SENT);
    tick(2);
    chk_bit(pause_req_o, 1'b0);
    wb(1'b1, OFS_FLOW, 32'h00021234);
    pulse(P_ON);
    tick(2);
    chk_bit(pause_req_o, 1'b1);
    chk_word({16'h0000, pause_val_o}, 32'h00001234);
    pulse(P_SENT);
    tick(2);
    pulse(P_ON);
    tick(2);
    chk_bit(pause_req_o, 1'b0);
    pulse(P_OFF);
    tick(2);
    chk_bit(pause_req_o, 1'b1);
    chk_word({16'h0000, pause_val_o}, 32'h00000000);
    pulse(P_SENT);
    tick(2);
  endtask
  task automatic t_pause_rx();
    wb(1'b1, OFS_FLOW, 32'h00050005);
    rx_pause(16'h0003, 1'b1);
    chk_bit(tx_hold_o, 1'b1);
    tick(350);
    chk_bit(tx_hold_o, 1'b0);
    rx_pause(16'h0064, 1'b1);
    chk_bit(tx_hold_o, 1'b1);
    rx_pause(16'h0000, 1'b1);
    chk_bit(tx_hold_o, 1'b0);
    pulse(P_START);
    rx_pause(16'h0064, 1'b1);
    chk_bit(tx_hold_o, 1'b0);
    pulse(P_END);
    tick(2);
    chk_bit(tx_hold_o, 1'b1);
    wb(1'b1, OFS_FLOW, 32'h00010005);
    rx_pause(16'h0000, 1'b0);
  endtask
  task automatic t_wake();
    wb(1'b1, OFS_WAKE_A, 32'h00000001);
    wb(1'b1, OFS_WAKE_B, 32'h00000002);
    wb(1'b1, OFS_PMC, 32'h00000033);
    clr();
    packet(6'h02);
    chk_bit(wake_o, 1'b0);
    packet(6'h21);
    chk_bit(wake_o, 1'b1);
    chk_bit(seen_store, 1'b1);
    rd_chk(OFS_WAKE_A, 32'h00000101);
    rd_chk(OFS_WAKE_B, 32'h00000202);
    rd_chk(OFS_CAUSE, 32'h00000021);
    resume();
    chk_bit(wake_o, 1'b0);
    rd_chk(OFS_WAKE_A, 32'h00000001);
    rd_chk(OFS_CAUSE, 32'h00000021);
    rd_chk(OFS_PMC, 32'h00000003);
    wb(1'b1, OFS_PMC, 32'h00000015);
    clr();
    packet(6'h01);
    chk_bit(wake_o, 1'b1);
    chk_bit(seen_store, 1'b0);
    resume();
    rd_chk(OFS_WAKE_A, 32'h00000100);
    rd_chk(OFS_WAKE_B, 32'h00000000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    {we_i, cyc_i, stb_i, tx_start_i, tx_end_i, pause_sent_i, flow_on_i} = 7'h00;
    {flow_off_i, rx_pause_det_i, pkt_end_i, host_resume_i, col_cmd} = 5'h00;
    adr_i = 8'h00;
    dat_i = 32'h0;
    sel_i = 4'h0;
    rx_pause_quanta_i = 16'h0;
    det_hits_i = 6'h00;
    rst_i = 1'b1;
    clr();
    tick(5);
    rst_i <= 1'b0;
    tick(1);
    t_regs();
    t_collision();
    t_pause_send();
    t_pause_rx();
    t_wake();
    test_done();
  end
  // The full run needs under 1500 cycles; this bound only cuts a hang.
  initial begin
    tick(20000);
    err("watchdog expired");
    test_done();
  end
endmodule
